// file: src/ccs_defs.svh
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ==========================================================
// register map (byte addresses on the apb bus)
`define CCS_ADDR_W 12
`define CCS_CTRL_OFS 12'h000
`define CCS_TRIM_OFS 12'h004
`define CCS_DIV_OFS 12'h008

// ==========================================================
// control register fields
`define CCS_CURRENT_SOURCE_FIELD_LSB 12
`define CCS_NEW_SOURCE_FIELD_LSB 8
`define CCS_FREEZE_BIT 7
`define CCS_LOCK_BIT 5
`define CCS_CF_BIT 3
`define CCS_KEEP_BIT 1
`define CCS_REQ_BIT 0

// ==========================================================
// unlock keys
`define CCS_KEY_HI1 8'h78
`define CCS_KEY_HI2 8'h9a
`define CCS_KEY_LO1 8'h46
`define CCS_KEY_LO2 8'h57

// ==========================================================
// trim and divisor fields
`define CCS_TRIM_LSB 7
`define CCS_TRIM_W 9
`define CCS_DIV_W 15
`define CCS_DIV_RESET 15'h0001
`define CCS_TRIM_RESET 9'h000

// ==========================================================
// source codes
`define CCS_SRC_FRC 3'h0
`define CCS_SRC_FRC_PLL 3'h1
`define CCS_SRC_PRI 3'h2
`define CCS_SRC_PRI_PLL 3'h3
`define CCS_SRC_SEC 3'h4
`define CCS_SRC_LOW_POWER_RC_OSC 3'h5
`define CCS_SRC_RSVD 3'h6
`define CCS_SRC_FDIV 3'h7

// ==========================================================
// timing counts
`define CCS_SETTLE_EDGES 10
`define CCS_CNT_W 8
`define CCS_BOOT_WAIT 2'h3

`endif

// file: src/ccs_edge_count.sv
`timescale 1ns/1ns
`default_nettype none
`include "ccs_defs.svh"

// ==========================================================
// counts rising edges of a sampled clock level while run is high
module ccs_edge_count #(
  parameter int COUNT = `CCS_SETTLE_EDGES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic clk_level,
  output logic done
);

  ccs_pkg::ccs_cnt_s r_reg;
  ccs_pkg::ccs_cnt_s r_next;
  logic lvl_s;

  ccs_sync #(.W(1)) u_lvl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(clk_level),
    .dout(lvl_s)
  );

  always_comb begin
    r_next = r_reg;
    r_next.lvl_d = lvl_s;
    if (!run) begin
      r_next.cnt = '0;
      r_next.done = 1'b0;
    end else if (lvl_s && !r_reg.lvl_d && !r_reg.done) begin
      if (r_reg.cnt == COUNT[`CCS_CNT_W-1:0] - 1'b1) begin
        r_next.done = 1'b1;
      end
      r_next.cnt = r_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;

endmodule // ccs_edge_count

`default_nettype wire

// file: src/ccs_pkg.sv
`include "ccs_defs.svh"

package ccs_pkg;

  typedef enum logic [2:0] {
    UL_IDLE,
    UL_HI_KEY,
    UL_HI_OPEN,
    UL_LO_KEY,
    UL_LO_OPEN
  } ccs_unlock_e;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT,
    SW_SETTLE,
    SW_DONE
  } ccs_switch_e;

  typedef struct packed {
    ccs_unlock_e unl;
    ccs_switch_e sw;
    logic boot_done;
    logic [1:0] boot_wait;
    logic [2:0] current_source_field;
    logic [2:0] new_source_field;
    logic freeze;
    logic lock;
    logic cf;
    logic keep;
    logic req;
    logic fail_d;
    logic [7:0] osc_en;
    logic [`CCS_TRIM_W-1:0] trim;
    logic [`CCS_DIV_W-1:0] div;
    logic [31:0] rdata;
  } ccs_state_s;

  typedef struct packed {
    logic [`CCS_CNT_W-1:0] cnt;
    logic lvl_d;
    logic done;
  } ccs_cnt_s;

endpackage

// file: src/ccs_switcher.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "ccs_defs.svh"

// Notes on behaviour
// - trim register holds 9 bits at 15:7 adding n/512; bits 6:0 read zero
// - switching and fail-safe monitor work only when the enable config is zero
// - with switching off, new source is ignored and current source shows boot source
// - with switching off, the request bit ignores writes and reads zero
// - high byte unlock is 78h then 9Ah, protected write follows directly
// - low byte unlock is 46h then 57h, request write follows directly
// - request for the source already in use is cleared and aborted
// - a real switch clears the pll lock bit and the clock fail flag
// - start new source, wait crystal timer or pll lock as it needs
// - count ten edges of the new clock before moving over
// - on completion clear request and copy new source into current source
// - stop the old source unless low-power rc or secondary must stay on
// - software keeps running during a switch and avoids timing-critical work
// - primary submodes are fixed; switching only enters or leaves primary
// - source codes as listed, with 110 reserved
// - lock bit shows pll locked, zero when unlocked, starting or unused
// - with fail-safe on and freeze bit set, selections are locked
module ccs_switcher #(
  parameter int SETTLE_EDGES = `CCS_SETTLE_EDGES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CCS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic switching_enable_config,
  input wire logic failsafe_select_config,
  input wire logic [2:0] boot_source_config,
  input wire logic watchdog_enable,
  input wire logic [7:0] osc_running,
  input wire logic [7:0] osc_clock_level,
  input wire logic crystal_startup_done,
  input wire logic pll_locked,
  input wire logic clock_fail_detect,
  output logic [7:0] osc_enable,
  output logic [2:0] sys_clock_select,
  output logic failsafe_monitor_enable,
  output logic switch_busy,
  output logic [`CCS_DIV_W-1:0] ref_divisor_int,
  output logic [`CCS_TRIM_W-1:0] ref_divisor_trim
);

  // ==========================================================
  // input synchronisers
  localparam int SYNC_W = 17;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic s_cfg_sw;
  logic s_cfg_fs;
  logic [2:0] s_boot;
  logic s_wdt;
  logic [7:0] s_run;
  logic s_ost;
  logic s_pll;
  logic s_fail;

  assign sync_in = {clock_fail_detect, pll_locked, crystal_startup_done, osc_running,
                    watchdog_enable, boot_source_config, failsafe_select_config,
                    switching_enable_config};

  ccs_sync #(.W(SYNC_W)) u_in_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(sync_in),
    .dout(sync_out)
  );

  assign s_cfg_sw = sync_out[0];
  assign s_cfg_fs = sync_out[1];
  assign s_boot = sync_out[4:2];
  assign s_wdt = sync_out[5];
  assign s_run = sync_out[13:6];
  assign s_ost = sync_out[14];
  assign s_pll = sync_out[15];
  assign s_fail = sync_out[16];

  // ==========================================================
  // state
  ccs_pkg::ccs_state_s r_reg;
  ccs_pkg::ccs_state_s r_next;

  logic settle_done;
  logic settle_run;

  assign settle_run = (r_reg.sw == ccs_pkg::SW_SETTLE);

  // ==========================================================
  // new-clock settling counter
  ccs_edge_count #(.COUNT(SETTLE_EDGES)) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .run(settle_run),
    .clk_level(osc_clock_level[r_reg.new_source_field]),
    .done(settle_done)
  );

  // ==========================================================
  // helpers
  function automatic logic is_pll(input logic [2:0] src);
    is_pll = (src == `CCS_SRC_FRC_PLL) || (src == `CCS_SRC_PRI_PLL);
  endfunction

  // primary with or without pll is one code each; the submode is never selected here
  function automatic logic is_crystal(input logic [2:0] src);
    is_crystal = (src == `CCS_SRC_PRI) || (src == `CCS_SRC_PRI_PLL);
  endfunction

  // ==========================================================
  // next-state logic
  logic sw_en;
  logic failsafe_clock_monitor_en;
  logic frozen;
  logic setup_rd;
  logic acc_wr;
  logic hi_wr;
  logic lo_wr;
  logic [7:0] hb;
  logic [7:0] lb;
  logic src_ready;
  logic pll_use;

  always_comb begin
    r_next = r_reg;
    sw_en = ~s_cfg_sw;
    failsafe_clock_monitor_en = ~s_cfg_sw & ~s_cfg_fs;
    frozen = failsafe_clock_monitor_en & r_reg.freeze;
    setup_rd = psel & ~penable & ~pwrite;
    acc_wr = psel & penable & pwrite;
    hi_wr = (pstrb[1:0] == 2'b10);
    lo_wr = (pstrb[1:0] == 2'b01);
    hb = pwdata[15:8];
    lb = pwdata[7:0];
    src_ready = s_run[r_reg.new_source_field];
    pll_use = 1'b0;

    // boot source is caught once the synchronised straps have settled
    if (!r_reg.boot_done) begin
      r_next.boot_wait = r_reg.boot_wait + 2'h1;
      if (r_reg.boot_wait == `CCS_BOOT_WAIT) begin
        r_next.boot_done = 1'b1;
        r_next.current_source_field = s_boot;
        r_next.new_source_field = s_boot;
      end
    end

    // ---- readback, captured in the setup phase ----
    if (setup_rd) begin
      if (paddr == `CCS_CTRL_OFS) begin
        r_next.rdata = {16'h0000, 1'b0, r_reg.current_source_field, 1'b0, r_reg.new_source_field, r_reg.freeze, 1'b0,
                        r_reg.lock, 1'b0, r_reg.cf, 1'b0, r_reg.keep, r_reg.req};
      end else if (paddr == `CCS_TRIM_OFS) begin
        r_next.rdata = {16'h0000, r_reg.trim, 7'h00};
      end else if (paddr == `CCS_DIV_OFS) begin
        r_next.rdata = {17'h00000, r_reg.div};
      end else begin
        r_next.rdata = 32'h0000_0000;
      end
    end

    // ---- switch sequencer ----
    case (r_reg.sw)
      ccs_pkg::SW_IDLE: begin
        if (r_reg.req) begin
          if (r_reg.new_source_field == r_reg.current_source_field) begin
            r_next.req = 1'b0;
          end else begin
            r_next.sw = ccs_pkg::SW_WAIT;
            r_next.lock = 1'b0;
            r_next.cf = 1'b0;
            r_next.osc_en[r_reg.new_source_field] = 1'b1;
          end
        end
      end
      ccs_pkg::SW_WAIT: begin
        if (is_crystal(r_reg.new_source_field)) begin
          src_ready = src_ready & s_ost;
        end
        if (is_pll(r_reg.new_source_field)) begin
          src_ready = src_ready & s_pll;
        end
        if (src_ready) begin
          r_next.sw = ccs_pkg::SW_SETTLE;
        end
      end
      ccs_pkg::SW_SETTLE: begin
        if (settle_done) begin
          r_next.sw = ccs_pkg::SW_DONE;
        end
      end
      ccs_pkg::SW_DONE: begin
        r_next.current_source_field = r_reg.new_source_field;
        r_next.req = 1'b0;
        r_next.osc_en[r_reg.current_source_field] = 1'b0;
        r_next.sw = ccs_pkg::SW_IDLE;
      end
      default: begin
        r_next.sw = ccs_pkg::SW_IDLE;
      end
    endcase

    // ---- pll lock status ----
    pll_use = is_pll(r_reg.current_source_field) || ((r_reg.sw != ccs_pkg::SW_IDLE) && is_pll(r_reg.new_source_field));
    if (!(r_reg.sw == ccs_pkg::SW_IDLE && r_reg.req && r_reg.new_source_field != r_reg.current_source_field)) begin
      r_next.lock = s_pll & pll_use;
    end

    // ---- clock fail flag: a new failure wins over the switch-start clear ----
    r_next.fail_d = s_fail;
    if (failsafe_clock_monitor_en && s_fail && !r_reg.fail_d) begin
      r_next.cf = 1'b1;
    end

    // ---- apb writes ----
    if (acc_wr) begin
      r_next.unl = ccs_pkg::UL_IDLE;
      if (paddr == `CCS_CTRL_OFS) begin
        if (hi_wr && r_reg.unl == ccs_pkg::UL_HI_OPEN) begin
          if (r_reg.sw == ccs_pkg::SW_IDLE && !frozen) begin
            r_next.new_source_field = hb[2:0];
          end
        end else if (lo_wr && r_reg.unl == ccs_pkg::UL_LO_OPEN) begin
          r_next.keep = lb[`CCS_KEEP_BIT];
          if (!frozen) begin
            r_next.freeze = lb[`CCS_FREEZE_BIT];
          end
          if (lb[`CCS_REQ_BIT] && sw_en && !frozen) begin
            r_next.req = 1'b1;
          end
        end else if (hi_wr && hb == `CCS_KEY_HI1) begin
          r_next.unl = ccs_pkg::UL_HI_KEY;
        end else if (hi_wr && r_reg.unl == ccs_pkg::UL_HI_KEY && hb == `CCS_KEY_HI2) begin
          r_next.unl = ccs_pkg::UL_HI_OPEN;
        end else if (lo_wr && lb == `CCS_KEY_LO1) begin
          r_next.unl = ccs_pkg::UL_LO_KEY;
        end else if (lo_wr && r_reg.unl == ccs_pkg::UL_LO_KEY && lb == `CCS_KEY_LO2) begin
          r_next.unl = ccs_pkg::UL_LO_OPEN;
        end
      end else if (paddr == `CCS_TRIM_OFS) begin
        if (pstrb[1]) begin
          r_next.trim[`CCS_TRIM_W-1:1] = pwdata[15:8];
        end
        if (pstrb[0]) begin
          r_next.trim[0] = pwdata[`CCS_TRIM_LSB];
        end
      end else if (paddr == `CCS_DIV_OFS) begin
        if (pstrb[1]) begin
          r_next.div[`CCS_DIV_W-1:8] = pwdata[14:8];
        end
        if (pstrb[0]) begin
          r_next.div[7:0] = pwdata[7:0];
        end
      end
    end

    // ---- switching disabled: follow the boot source, no request ----
    if (!sw_en) begin
      r_next.sw = ccs_pkg::SW_IDLE;
      r_next.req = 1'b0;
      if (r_reg.boot_done) begin
        r_next.current_source_field = s_boot;
      end
    end

    // ---- oscillator enables ----
    if (r_reg.boot_done) begin
      r_next.osc_en[r_next.current_source_field] = 1'b1;
    end
    if (s_wdt || failsafe_clock_monitor_en) begin
      r_next.osc_en[`CCS_SRC_LOW_POWER_RC_OSC] = 1'b1;
    end
    if (r_reg.keep) begin
      r_next.osc_en[`CCS_SRC_SEC] = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg.unl <= ccs_pkg::UL_IDLE;
      r_reg.sw <= ccs_pkg::SW_IDLE;
      r_reg.boot_done <= 1'b0;
      r_reg.boot_wait <= 2'h0;
      r_reg.current_source_field <= `CCS_SRC_FRC;
      r_reg.new_source_field <= `CCS_SRC_FRC;
      r_reg.freeze <= 1'b0;
      r_reg.lock <= 1'b0;
      r_reg.cf <= 1'b0;
      r_reg.keep <= 1'b0;
      r_reg.req <= 1'b0;
      r_reg.fail_d <= 1'b0;
      r_reg.osc_en <= 8'h00;
      r_reg.trim <= `CCS_TRIM_RESET;
      r_reg.div <= `CCS_DIV_RESET;
      r_reg.rdata <= 32'h0000_0000;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = r_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr != `CCS_CTRL_OFS) & (paddr != `CCS_TRIM_OFS)
                   & (paddr != `CCS_DIV_OFS);
  assign osc_enable = r_reg.osc_en;
  assign sys_clock_select = r_reg.current_source_field;
  assign failsafe_monitor_enable = failsafe_clock_monitor_en;
  assign switch_busy = (r_reg.sw != ccs_pkg::SW_IDLE);
  assign ref_divisor_int = r_reg.div;
  assign ref_divisor_trim = r_reg.trim;

endmodule // ccs_switcher

`default_nettype wire

// file: src/ccs_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// two-stage synchroniser for asynchronous levels
module ccs_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ccs_sync_s;

  ccs_sync_s r_reg;
  ccs_sync_s r_next;

  always_comb begin
    r_next.s1 = din;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign dout = r_reg.s2;

endmodule // ccs_sync

`default_nettype wire

// file: tb/ccs_switcher_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "ccs_defs.svh"

// ==========================================================
// port-level checks of the switcher
module ccs_switcher_checker #(
  parameter int SETTLE_EDGES = `CCS_SETTLE_EDGES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CCS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic switching_enable_config,
  input wire logic [2:0] boot_source_config,
  input wire logic [7:0] osc_enable,
  input wire logic [2:0] sys_clock_select,
  input wire logic failsafe_monitor_enable,
  input wire logic switch_busy,
  input wire logic [`CCS_TRIM_W-1:0] ref_divisor_trim
);
  // cycles since reset release, saturating
  logic [3:0] age_reg;
  wire logic rd_trim = psel && penable && !pwrite && paddr == `CCS_TRIM_OFS;
  wire logic [8:0] trim_in = pwdata[15:7];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_reg <= 4'h0;
    end else if (age_reg != 4'h8) begin
      age_reg <= age_reg + 4'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_trim_low_zero: assert property (rd_trim |-> prdata[6:0] == 7'h00 && prdata[31:16] == 16'h0000)
    else $error("trim unused bits nonzero");
  a_trim_read_back: assert property (rd_trim |-> prdata[15:7] == ref_divisor_trim)
    else $error("trim read differs");
  a_trim_write_full: assert property (psel && penable && pwrite && paddr == `CCS_TRIM_OFS && pstrb == 4'hf
    |=> ref_divisor_trim == $past(trim_in))
    else $error("trim write lost");
  a_req_blocked: assert property (psel && penable && !pwrite && paddr == `CCS_CTRL_OFS && switching_enable_config
    |-> prdata[0] == 1'b0)
    else $error("request set while disabled");
  a_boot_source_shown: assert property (age_reg == 4'h8 && switching_enable_config
    |-> sys_clock_select == boot_source_config)
    else $error("current source not boot source");
  a_monitor_needs_enable: assert property (age_reg >= 4'h4 && failsafe_monitor_enable
    |-> !switching_enable_config)
    else $error("monitor on while disabled");
  a_current_running: assert property (age_reg == 4'h8 |-> osc_enable[sys_clock_select])
    else $error("current source not enabled");
  a_select_at_done: assert property (age_reg == 4'h8 && $changed(sys_clock_select) |-> $fell(switch_busy))
    else $error("source moved outside completion");
  a_busy_settle_min: assert property ($rose(switch_busy) |-> switch_busy [*8])
    else $error("switch ended too soon");
endmodule // ccs_switcher_checker

bind ccs_switcher ccs_switcher_checker #(.SETTLE_EDGES(SETTLE_EDGES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .switching_enable_config(switching_enable_config), .boot_source_config(boot_source_config),
  .osc_enable(osc_enable), .sys_clock_select(sys_clock_select),
  .failsafe_monitor_enable(failsafe_monitor_enable), .switch_busy(switch_busy),
  .ref_divisor_trim(ref_divisor_trim)
);

`default_nettype wire

// file: tb/ccs_switcher_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ccs_defs.svh"

// ==========================================================
// self-checking bench
module ccs_switcher_tb;
  localparam int SET = 10;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic e;
  logic sw_cfg;
  logic pll_lk;
  logic busy;
  logic fs_en;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] r;
  logic [3:0] pstrb;
  logic [2:0] boot;
  logic [2:0] sel;
  logic [7:0] lvl;
  logic [7:0] oen;
  logic [8:0] trim_o;
  logic [14:0] div_o;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  ccs_switcher #(.SETTLE_EDGES(SET)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .switching_enable_config(sw_cfg), .failsafe_select_config(1'b0),
    .boot_source_config(boot), .watchdog_enable(1'b0), .osc_running(8'hff),
    .osc_clock_level(lvl), .crystal_startup_done(1'b1), .pll_locked(pll_lk),
    .clock_fail_detect(1'b0), .osc_enable(oen), .sys_clock_select(sel),
    .failsafe_monitor_enable(fs_en), .switch_busy(busy), .ref_divisor_int(div_o),
    .ref_divisor_trim(trim_o)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic close_out;
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, byte b copied to both low lanes, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] b, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, b, b};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rst(input logic c, input logic [2:0] b);
    presetn <= 1'b0;
    sw_cfg <= c;
    boot <= b;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  task automatic key(input logic [3:0] s, input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] v);
    apb(1'b1, `CCS_CTRL_OFS, k1, s);
    apb(1'b1, `CCS_CTRL_OFS, k2, s);
    apb(1'b1, `CCS_CTRL_OFS, v, s);
  endtask

  task automatic go(input logic [7:0] code);
    key(4'h2, `CCS_KEY_HI1, `CCS_KEY_HI2, code);
    key(4'h1, `CCS_KEY_LO1, `CCS_KEY_LO2, 8'h01);
  endtask

  task automatic edges(input int n);
    repeat (n) begin
      lvl[3] <= 1'b1;
      repeat (2) @(posedge pclk);
      lvl[3] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  task automatic t_regs;
    apb(1'b0, `CCS_TRIM_OFS, 8'h00, 4'h0);
    chk(r, 32'h0);
    chk(div_o, 32'h1);
    apb(1'b1, `CCS_TRIM_OFS, 8'hff, 4'hf);
    apb(1'b0, `CCS_TRIM_OFS, 8'h00, 4'h0);
    chk(r, 32'h0000ff80);
    chk(trim_o, 32'h1ff);
    apb(1'b0, 12'h00c, 8'h00, 4'h0);
    chk(e, 32'h1);
    chk(r, 32'h0);
  endtask

  task automatic t_switch;
    chk(fs_en, 32'h1);
    go(8'h03);
    repeat (6) @(posedge pclk);
    apb(1'b0, `CCS_CTRL_OFS, 8'h00, 4'h0);
    chk(r & 32'h0729, 32'h0301);
    chk(busy, 32'h1);
    pll_lk <= 1'b1;
    repeat (6) @(posedge pclk);
    edges(SET - 1);
    chk(busy, 32'h1);
    edges(1);
    repeat (20) if (busy) @(posedge pclk);
    apb(1'b0, `CCS_CTRL_OFS, 8'h00, 4'h0);
    chk(r & 32'h7721, 32'h3320);
    chk(sel, 32'h3);
    chk(oen[0], 32'h0);
  endtask

  task automatic t_redundant;
    go(8'h03);
    repeat (6) @(posedge pclk);
    apb(1'b0, `CCS_CTRL_OFS, 8'h00, 4'h0);
    chk(r & 32'h7001, 32'h3000);
    chk(busy, 32'h0);
  endtask

  task automatic t_void;
    apb(1'b1, `CCS_CTRL_OFS, `CCS_KEY_HI1, 4'h2);
    apb(1'b1, `CCS_TRIM_OFS, 8'h00, 4'hf);
    apb(1'b1, `CCS_CTRL_OFS, `CCS_KEY_HI2, 4'h2);
    apb(1'b1, `CCS_CTRL_OFS, 8'h00, 4'h2);
    apb(1'b0, `CCS_CTRL_OFS, 8'h00, 4'h0);
    chk(r & 32'h0700, 32'h0300);
    key(4'h2, `CCS_KEY_HI1, 8'h9b, 8'h00);
    apb(1'b0, `CCS_CTRL_OFS, 8'h00, 4'h0);
    chk(r & 32'h0700, 32'h0300);
  endtask

  task automatic t_off;
    rst(1'b1, 3'h2);
    go(8'h00);
    repeat (6) @(posedge pclk);
    apb(1'b0, `CCS_CTRL_OFS, 8'h00, 4'h0);
    chk(r & 32'h7001, 32'h2000);
    chk(sel, 32'h2);
    chk(fs_en, 32'h0);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    sw_cfg = 1'b0;
    boot = 3'h0;
    pll_lk = 1'b0;
    lvl = 8'h00;
    rst(1'b0, 3'h0);
    t_regs();
    t_switch();
    t_redundant();
    t_void();
    t_off();
    close_out();
  end
endmodule // ccs_switcher_tb

`default_nettype wire
